// ==== common/dds_pkg.sv ====
// Constants shared by the serial control port and its frequency store
package dds_pkg;
   localparam int unsigned WORD_BITS      = 16;
   localparam int unsigned BIT_CNT_W      = 4;
   localparam logic [3:0]  LAST_BIT       = 4'hF;
   localparam int unsigned FREQ_W         = 28;
   localparam int unsigned HALF_W         = 14;
   localparam int unsigned PHASE_W        = 12;
   localparam int unsigned CTRL_W         = 14;
   localparam int unsigned SYNC_LINES     = 3;

   // Top two bits of a received word, and the phase bank bit below them
   localparam logic [1:0]  ADDR_CONTROL   = 2'h0;
   localparam logic [1:0]  ADDR_FREQ_A    = 2'h1;
   localparam logic [1:0]  ADDR_FREQ_B    = 2'h2;
   localparam logic [1:0]  ADDR_PHASE     = 2'h3;
   localparam int unsigned PHASE_BANK_BIT = 13;

   // Control field positions
   localparam int unsigned FULL_WORD_BIT  = 13;
   localparam int unsigned HALF_SEL_BIT   = 12;
   localparam int unsigned FREQ_SEL_BIT   = 11;
   localparam int unsigned PHASE_SEL_BIT  = 10;
   localparam int unsigned RESET_BIT      = 8;
   localparam int unsigned MODE_BIT       = 1;

   localparam logic [13:0] CTRL_RESET_VAL = 14'h0100;
   localparam logic [27:0] FREQ_RESET_VAL = 28'h0000000;
   localparam logic [11:0] PHASE_RESET_VAL = 12'h000;

   // Output latency in master clock cycles from the loading write
   localparam int unsigned LATENCY_CYCLES = 7;
   localparam int unsigned PIPE_DEPTH     = LATENCY_CYCLES - 2;
endpackage

// ==== design/freq_word_store.sv ====
// Two frequency words with half-word writes and a registered read port
`timescale 1ns/10ps
module freq_word_store
   import dds_pkg::*;
(
   input  wire logic              clock_in,
   input  wire logic              rst_n_in,
   input  wire logic              wr_bank_in,
   input  wire logic              wr_hi_in,
   input  wire logic              wr_lo_in,
   input  wire logic [FREQ_W-1:0] wr_data_in,
   input  wire logic              rd_bank_in,
   output logic      [FREQ_W-1:0] rd_data_out
);
   logic [FREQ_W-1:0] word_reg [2];

   // Write each half of the addressed word independently
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : bank
         always_ff @(posedge clock_in) begin
            if (!rst_n_in) begin
               word_reg[g] <= FREQ_RESET_VAL;
            end else if (wr_bank_in == 1'(g)) begin
               if (wr_hi_in) begin
                  word_reg[g][FREQ_W-1:HALF_W] <= wr_data_in[FREQ_W-1:HALF_W];
               end
               if (wr_lo_in) begin
                  word_reg[g][HALF_W-1:0] <= wr_data_in[HALF_W-1:0];
               end
            end
         end
      end
   endgenerate

   // Bank select zero reads the first word, one the second
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         rd_data_out <= FREQ_RESET_VAL;
      end else begin
         rd_data_out <= word_reg[rd_bank_in]; // (RULE17) (RULE20)
      end
   end
endmodule

// ==== design/dds_serial_control_port.sv ====
// Serial word receiver, control decoder and phase path of the waveform generator
//
// Contract
// (RULE1) One 16-bit word per serial transfer
// (RULE2) Accept bits only while frame sync low
// (RULE3) Shift one bit per falling serial clock
// (RULE4) Each 16 bits form a back-to-back word
// (RULE5) Host raises frame sync after 16th edge
// (RULE6) Serial clock high when frame sync falls
// (RULE7) Host holds reset bit during setup
// (RULE8) Reset bit keeps frequency, phase, control
// (RULE9) Output follows reset release by seven cycles
// (RULE10) Register loads reach output in seven cycles
// (RULE11) Control bits sampled into core stage
// (RULE12) Top bits zero means control write
// (RULE13) Full load: low half then high half
// (RULE14) Full load updates register atomically
// (RULE15) Half mode writes one half only
// (RULE16) Half select routes upper or lower half
// (RULE17) Frequency bank select feeds accumulator
// (RULE18) Reset bit clears accumulator to midscale; code clears it to zero
// (RULE19) Phase bank select picks phase offset
// (RULE20) Select zero first bank, one second
`timescale 1ns/10ps
module dds_serial_control_port
   import dds_pkg::*;
(
   input  wire logic               clock_in,
   input  wire logic               rst_n_in,
   input  wire logic               sclk_in,
   input  wire logic               sdata_in,
   input  wire logic               frame_sync_n_in,
   output logic      [PHASE_W-1:0] phase_word_out,
   output logic                    gen_active_out,
   output logic      [CTRL_W-1:0]  control_bits_out
);
   // Pin synchronisers for clock, data and frame sync
   logic [SYNC_LINES-1:0] sync1_reg;
   logic [SYNC_LINES-1:0] sync2_reg;
   logic [SYNC_LINES-1:0] pins;
   logic                  sclk_prev_reg;
   logic                  sclk_s;
   logic                  sdata_s;
   logic                  frame_sync_n_s;
   logic                  sclk_fall;

   assign pins = {frame_sync_n_in, sdata_in, sclk_in};

   genvar g;
   generate
      for (g = 0; g < SYNC_LINES; g++) begin : sync
         always_ff @(posedge clock_in) begin
            if (!rst_n_in) begin
               sync1_reg[g] <= 1'b1;
               sync2_reg[g] <= 1'b1;
            end else begin
               sync1_reg[g] <= pins[g];
               sync2_reg[g] <= sync1_reg[g];
            end
         end
      end
   endgenerate

   assign sclk_s         = sync2_reg[0];
   assign sdata_s        = sync2_reg[1];
   assign frame_sync_n_s = sync2_reg[2];

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sclk_prev_reg <= 1'b1;
      end else begin
         sclk_prev_reg <= sclk_s;
      end
   end

   assign sclk_fall = sclk_prev_reg && !sclk_s;

   // Input shift register and bit counter
   logic [WORD_BITS-1:0] shift_reg;
   logic [WORD_BITS-1:0] shift_next;
   logic [BIT_CNT_W-1:0] bit_cnt_reg;
   logic                 word_done_reg;
   logic [WORD_BITS-1:0] word_reg;

   assign shift_next = {shift_reg[WORD_BITS-2:0], sdata_s};

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         shift_reg <= '0;
      end else if (!frame_sync_n_s && sclk_fall) begin
         shift_reg <= shift_next; // (RULE3)
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         bit_cnt_reg   <= '0;
         word_done_reg <= 1'b0;
         word_reg      <= '0;
      end else if (frame_sync_n_s) begin
         bit_cnt_reg   <= '0; // (RULE2)
         word_done_reg <= 1'b0;
      end else if (sclk_fall) begin
         bit_cnt_reg   <= bit_cnt_reg + 4'h1; // (RULE1)
         word_done_reg <= (bit_cnt_reg == LAST_BIT);
         if (bit_cnt_reg == LAST_BIT) begin
            word_reg <= shift_next; // (RULE4)
         end
      end else begin
         word_done_reg <= 1'b0;
      end
   end

   // Decode of a finished word
   logic [1:0]          word_addr;
   logic [HALF_W-1:0]   word_data;
   logic                is_control;
   logic                is_freq;
   logic                freq_bank;

   assign word_addr  = word_reg[WORD_BITS-1:WORD_BITS-2];
   assign word_data  = word_reg[HALF_W-1:0];
   assign is_control = word_done_reg && (word_addr == ADDR_CONTROL); // (RULE12)
   assign is_freq    = word_done_reg &&
                       ((word_addr == ADDR_FREQ_A) || (word_addr == ADDR_FREQ_B));
   assign freq_bank  = (word_addr == ADDR_FREQ_B);

   // Control word register
   logic [CTRL_W-1:0] ctrl_reg;
   logic              full_word_load;
   logic              half_select;

   assign full_word_load = ctrl_reg[FULL_WORD_BIT];
   assign half_select    = ctrl_reg[HALF_SEL_BIT];

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         ctrl_reg <= CTRL_RESET_VAL;
      end else if (is_control) begin
         ctrl_reg <= word_data; // (RULE12)
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         control_bits_out <= CTRL_RESET_VAL;
      end else begin
         control_bits_out <= ctrl_reg;
      end
   end

   // Frequency write staging, full-word pairing and half routing
   logic              pend_reg;
   logic              pend_bank_reg;
   logic [HALF_W-1:0] pend_low_reg;
   logic              wr_bank_reg;
   logic              wr_hi_reg;
   logic              wr_lo_reg;
   logic [FREQ_W-1:0] wr_data_reg;

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         pend_reg      <= 1'b0;
         pend_bank_reg <= 1'b0;
         pend_low_reg  <= '0;
      end else if (is_control && !word_data[FULL_WORD_BIT]) begin
         pend_reg <= 1'b0;
      end else if (is_freq && full_word_load) begin
         if (pend_reg && (pend_bank_reg == freq_bank)) begin
            pend_reg <= 1'b0; // (RULE13)
         end else begin
            pend_reg      <= 1'b1;
            pend_bank_reg <= freq_bank;
            pend_low_reg  <= word_data;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         wr_bank_reg <= 1'b0;
         wr_hi_reg   <= 1'b0;
         wr_lo_reg   <= 1'b0;
         wr_data_reg <= '0;
      end else begin
         wr_bank_reg <= freq_bank;
         wr_data_reg <= {word_data, word_data};
         wr_hi_reg   <= 1'b0;
         wr_lo_reg   <= 1'b0;
         if (is_freq && full_word_load) begin
            if (pend_reg && (pend_bank_reg == freq_bank)) begin
               wr_hi_reg   <= 1'b1; // (RULE14)
               wr_lo_reg   <= 1'b1;
               wr_data_reg <= {word_data, pend_low_reg};
            end
         end else if (is_freq) begin
            wr_hi_reg <= half_select; // (RULE15) (RULE16)
            wr_lo_reg <= !half_select;
         end
      end
   end

   // Phase offset registers
   logic [PHASE_W-1:0] phase_offset_a;
   logic [PHASE_W-1:0] phase_offset_b;

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         phase_offset_a <= PHASE_RESET_VAL;
         phase_offset_b <= PHASE_RESET_VAL;
      end else if (word_done_reg && (word_addr == ADDR_PHASE)) begin
         if (word_reg[PHASE_BANK_BIT]) begin
            phase_offset_b <= word_reg[PHASE_W-1:0];
         end else begin
            phase_offset_a <= word_reg[PHASE_W-1:0];
         end
      end
   end

   // Core stage samples the control bits once per master clock
   logic [CTRL_W-1:0] ctrl_core_reg;
   logic              core_reset;

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         ctrl_core_reg <= CTRL_RESET_VAL;
      end else begin
         ctrl_core_reg <= ctrl_reg; // (RULE11)
      end
   end

   assign core_reset = ctrl_core_reg[RESET_BIT];
   logic [FREQ_W-1:0] freq_rd;
   freq_word_store store (
      .clock_in   (clock_in),
      .rst_n_in   (rst_n_in),
      .wr_bank_in (wr_bank_reg),
      .wr_hi_in   (wr_hi_reg),
      .wr_lo_in   (wr_lo_reg),
      .wr_data_in (wr_data_reg),
      .rd_bank_in (ctrl_core_reg[FREQ_SEL_BIT]),
      .rd_data_out(freq_rd)
   );

   // Phase accumulator, cleared but registers kept while reset bit is set
   logic [FREQ_W-1:0] acc_reg;

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         acc_reg <= '0;
      end else if (core_reset) begin
         acc_reg <= '0; // (RULE18) (RULE8)
      end else begin
         acc_reg <= acc_reg + freq_rd; // (RULE17)
      end
   end

   // Phase adder and output latency line; offset delayed to match the frequency path
   logic [PHASE_W-1:0] phase_sel;
   logic [PHASE_W-1:0] phase_sel_reg;
   logic [PHASE_W-1:0] phase_late_reg;
   logic [PHASE_W-1:0] sum_pipe_reg [PIPE_DEPTH];
   logic [PIPE_DEPTH-1:0] active_pipe_reg;
   assign phase_sel = ctrl_core_reg[PHASE_SEL_BIT] ? phase_offset_b : phase_offset_a; // (RULE19)

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         phase_sel_reg      <= PHASE_RESET_VAL;
         phase_late_reg     <= PHASE_RESET_VAL;
         sum_pipe_reg[0]    <= '0;
         active_pipe_reg[0] <= 1'b0;
      end else begin
         phase_sel_reg      <= phase_sel;
         phase_late_reg     <= phase_sel_reg; // (RULE10)
         sum_pipe_reg[0]    <= acc_reg[FREQ_W-1:FREQ_W-PHASE_W] + phase_late_reg;
         active_pipe_reg[0] <= !core_reset; // (RULE9)
      end
   end

   generate
      for (g = 1; g < PIPE_DEPTH; g++) begin : pipe
         always_ff @(posedge clock_in) begin
            if (!rst_n_in) begin
               sum_pipe_reg[g]    <= '0;
               active_pipe_reg[g] <= 1'b0;
            end else begin
               sum_pipe_reg[g]    <= sum_pipe_reg[g-1]; // (RULE10)
               active_pipe_reg[g] <= active_pipe_reg[g-1];
            end
         end
      end
   endgenerate
   assign phase_word_out = sum_pipe_reg[PIPE_DEPTH-1];
   assign gen_active_out = active_pipe_reg[PIPE_DEPTH-1];

   // Checks
   frame_idle_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // (RULE2)
      frame_sync_n_s |=> (bit_cnt_reg == 4'h0) && !word_done_reg)
      else $error("bit counter not cleared while frame sync high");
   bit_shift_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // (RULE3)
      (!frame_sync_n_s && sclk_fall) |=>
         (bit_cnt_reg == $past(bit_cnt_reg) + 4'h1) && (shift_reg[0] == $past(sdata_s)))
      else $error("falling serial clock did not shift one bit");
   word_group_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // (RULE4)
      (!frame_sync_n_s && sclk_fall && bit_cnt_reg == LAST_BIT) |=>
         word_done_reg && (bit_cnt_reg == 4'h0) ##1 !word_done_reg)
      else $error("sixteenth bit did not complete a word");
   ctrl_decode_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // (RULE12)
      (word_done_reg && word_addr == ADDR_CONTROL) |=> ctrl_reg == $past(word_data))
      else $error("control word not stored");
   atomic_load_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // (RULE14)
      (is_freq && full_word_load && !pend_reg) |=> !wr_hi_reg && !wr_lo_reg && pend_reg)
      else $error("first half of full load reached the frequency register");
   half_route_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // (RULE16)
      (is_freq && !full_word_load) |=>
         (wr_hi_reg == $past(half_select)) && (wr_lo_reg != $past(half_select)))
      else $error("half write routed to the wrong half");
   reset_keep_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // (RULE8)
      (core_reset && !word_done_reg) |=> $stable(phase_offset_a) && $stable(phase_offset_b))
      else $error("reset bit disturbed the phase registers");
   acc_clear_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // (RULE18)
      core_reset |=> acc_reg == 28'h0000000)
      else $error("accumulator not cleared under reset bit");
   acc_step_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // (RULE17)
      !core_reset |=> acc_reg == $past(acc_reg) + $past(freq_rd))
      else $error("accumulator did not add selected frequency");
   reset_latency_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // (RULE9)
      (is_control && ctrl_reg[RESET_BIT] && !word_data[RESET_BIT] && !gen_active_out) |->
         ##6 !gen_active_out ##1 gen_active_out)
      else $error("output not started seven cycles after reset release");
   phase_pick_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // (RULE19)
      1'b1 |=> phase_sel_reg ==
         ($past(ctrl_core_reg[PHASE_SEL_BIT]) ? $past(phase_offset_b) : $past(phase_offset_a)))
      else $error("wrong phase offset selected");
   phase_delay_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // (RULE10)
      1'b1 |=> sum_pipe_reg[0] ==
         12'($past(acc_reg[FREQ_W-1:FREQ_W-PHASE_W]) + $past(phase_sel, 3)))
      else $error("phase offset reached the adder with the wrong delay");
endmodule

// ==== tb/serial_host_model.sv ====
// Serial host model that writes 16-bit words over the three-wire link
`timescale 1ns/10ps
module serial_host_model (
   output logic sclk_out,
   output logic sdata_out,
   output logic frame_sync_n_out
);
   localparam int HALF_NS = 80;

   initial begin
      sclk_out = 1'b1;
      sdata_out = 1'b0;
      frame_sync_n_out = 1'b1;
   end

   // Clock stands high outside frames, so it is high when frame sync falls
   task automatic open_frame();
      if (frame_sync_n_out) begin
         #HALF_NS;
         frame_sync_n_out = 1'b0;
         #HALF_NS;
      end
   endtask

   // Most significant bit first, one bit per falling clock
   task automatic shift_bits(input logic [15:0] w, input int n);
      open_frame();
      for (int i = 0; i < n; i++) begin
         sdata_out = w[15-i];
         #HALF_NS;
         sclk_out = 1'b0;
         #HALF_NS;
         sclk_out = 1'b1;
      end
   endtask

   // Frame sync rises only after the last falling edge; data line goes stale
   task automatic close_frame();
      #HALF_NS;
      frame_sync_n_out = 1'b1;
      sdata_out = ~sdata_out;
   endtask

   // Frame held low across several words when last is clear
   task automatic send_word(input logic [15:0] w, input bit last);
      shift_bits(w, 16);
      if (last) begin
         close_frame();
      end
   endtask

   // Cut a word short, then clock with frame sync high
   task automatic abort_bits(input logic [15:0] w, input int n);
      shift_bits(w, n);
      close_frame();
      repeat (4) begin
         #HALF_NS;
         sclk_out = 1'b0;
         sdata_out = ~sdata_out;
         #HALF_NS;
         sclk_out = 1'b1;
      end
   endtask
endmodule

// ==== tb/dds_serial_control_port_tb.sv ====
// Self-checking bench for the serial control port
`timescale 1ns/10ps
module dds_serial_control_port_tb;
   import dds_pkg::*;
   logic                clock_in;
   logic                rst_n_in;
   wire logic           sclk;
   wire logic           sdata;
   wire logic           frame_sync_n_n;
   logic [PHASE_W-1:0]  phase_word_out;
   logic                gen_active_out;
   logic [CTRL_W-1:0]   control_bits_out;
   int                  error_cnt = 0;
   int                  num_checks = 0;
   int                  cycles = 0;
   int                  lat = 0;
   logic [CTRL_W-1:0]   exp_q[$];
   logic [CTRL_W-1:0]   prev_ctrl = CTRL_RESET_VAL;
   logic                prev_ga = 1'b0;
   logic                prev_c8 = 1'b1;
   logic [11:0]         pa;
   logic [11:0]         pb;
   logic [13:0]         r1;

   serial_host_model serial_host_model_i (
      .sclk_out         (sclk),
      .sdata_out        (sdata),
      .frame_sync_n_out (frame_sync_n_n)
   );

   dds_serial_control_port dds_serial_control_port_i (
      .clock_in         (clock_in),
      .rst_n_in         (rst_n_in),
      .sclk_in          (sclk),
      .sdata_in         (sdata),
      .frame_sync_n_in  (frame_sync_n_n),
      .phase_word_out   (phase_word_out),
      .gen_active_out   (gen_active_out),
      .control_bits_out (control_bits_out)
   );

   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end

   task automatic check_ctrl(input string name, input logic [13:0] exp, input logic [13:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_phase(input string name, input logic [11:0] exp, input logic [11:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic cycles_wait(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask

   task automatic ctrl_write(input logic [13:0] c, input bit last);
      exp_q.push_back(c);
      serial_host_model_i.send_word({ADDR_CONTROL, c}, last);
   endtask

   task automatic data_write(input logic [1:0] a, input logic [13:0] v, input bit last);
      serial_host_model_i.send_word({a, v}, last);
   endtask

   // Accumulator top bits advance by the selected increment each cycle
   task automatic check_step(input logic [11:0] exp);
      logic [11:0] a;
      cycles_wait(14);
      a = phase_word_out;
      cycles_wait(1);
      check_phase("phase step", exp, phase_word_out - a);
   endtask

   // Oldest expected control value is taken whenever the output changes
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         prev_ctrl = CTRL_RESET_VAL;
      end else if (control_bits_out !== prev_ctrl) begin
         prev_ctrl = control_bits_out;
         check_ctrl("control_bits", exp_q.size() != 0 ? exp_q.pop_front() : ~control_bits_out,
                    control_bits_out);
      end
   end

   // Cycles from control update with reset bit cleared to generation start
   always @(posedge clock_in) begin
      if (prev_c8 === 1'b1 && control_bits_out[RESET_BIT] === 1'b0) begin
         lat <= 1;
      end else if (lat != 0) begin
         lat <= lat + 1;
      end
      if (gen_active_out === 1'b1 && prev_ga === 1'b0) begin
         check_phase("release latency", 12'(LATENCY_CYCLES - 2), 12'(lat));
      end
      prev_ga <= gen_active_out;
      prev_c8 <= control_bits_out[RESET_BIT];
   end

   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         finish_test();
      end
   end

   initial begin
      rst_n_in = 1'b0;
      void'($urandom(32'h3F80));
      r1 = 14'($urandom & 32'hFF) | 14'h0001;
      pa = 12'($urandom);
      pb = pa ^ 12'(1 + $urandom % 4095);
      repeat (5) @(posedge clock_in);
      #1;
      rst_n_in = 1'b1;
      cycles_wait(3);
      check_ctrl("control reset", CTRL_RESET_VAL, control_bits_out);
      check_phase("phase reset", 12'h000, phase_word_out);
      check_phase("active reset", 12'h000, {11'h000, gen_active_out});
      serial_host_model_i.abort_bits(16'h0000, 8);
      ctrl_write(14'h0100 | r1, 1'b0);
      data_write(ADDR_PHASE, {2'h0, pa}, 1'b0);
      data_write(ADDR_PHASE, {2'h2, pb}, 1'b0);
      ctrl_write(14'h0000 | r1, 1'b1);
      cycles_wait(20);
      check_phase("phase a", pa, phase_word_out);
      ctrl_write(14'h0400 | r1, 1'b1);
      cycles_wait(20);
      check_phase("phase b", pb, phase_word_out);
      ctrl_write(14'h2000 | r1, 1'b0);
      data_write(ADDR_FREQ_A, 14'h0000, 1'b0);
      data_write(ADDR_FREQ_A, 14'h0004, 1'b1);
      check_step(12'h001);
      ctrl_write(14'h1000 | r1, 1'b0);
      data_write(ADDR_FREQ_B, 14'h000C, 1'b1);
      check_step(12'h001);
      ctrl_write(14'h1800 | r1, 1'b1);
      check_step(12'h003);
      ctrl_write(14'h1000 | r1, 1'b0);
      data_write(ADDR_FREQ_A, 14'h0008, 1'b1);
      check_step(12'h002);
      ctrl_write(14'h1100 | r1, 1'b1);
      cycles_wait(20);
      check_phase("held phase", pa, phase_word_out);
      check_phase("active held", 12'h000, {11'h000, gen_active_out});
      ctrl_write(14'h1000 | r1, 1'b1);
      check_step(12'h002);
      cycles_wait(20);
      check_phase("queue left", 12'h000, 12'(exp_q.size()));
      finish_test();
   end
endmodule
